// ===== hdl/clp_regs.vh
`ifndef CLP_REGS_VH
`define CLP_REGS_VH
// Register word addresses
`define CLP_ADDR_MODE 4'h0
`define CLP_ADDR_TIMING 4'h1
`define CLP_ADDR_SLOT 4'h2
`define CLP_ADDR_FILTER 4'h3
`define CLP_ADDR_STATUS 4'h4
// MODE register bit positions
`define CLP_MODE_ADDR_PLACE 0
`define CLP_MODE_INT_LOOP 1
`define CLP_MODE_EXT_LOOP 2
`define CLP_MODE_PROMISC 3
`define CLP_MODE_BCAST_DIS 4
`define CLP_MODE_MANCH 5
`define CLP_MODE_TX_NO_CARRIER 6
`define CLP_MODE_NO_CRC 7
`define CLP_MODE_CRC16 8
`define CLP_MODE_BITSTUFF 9
`define CLP_MODE_PAD 10
`define CLP_MODE_INT_CARRIER 11
`define CLP_MODE_INT_COLL 12
`define CLP_MODE_BACKOFF_MET 13
`define CLP_MODE_PREAM_LSB 14
`define CLP_MODE_PREAM_MSB 15
// TIMING register fields
`define CLP_TIM_LIN_LSB 0
`define CLP_TIM_LIN_MSB 2
`define CLP_TIM_EXP_LSB 4
`define CLP_TIM_EXP_MSB 6
`define CLP_TIM_ALEN_LSB 8
`define CLP_TIM_ALEN_MSB 10
`define CLP_TIM_IFS_LSB 16
`define CLP_TIM_IFS_MSB 23
// SLOT register fields
`define CLP_SLOT_LSB 0
`define CLP_SLOT_MSB 10
`define CLP_MINF_LSB 16
`define CLP_MINF_MSB 23
// FILTER register fields
`define CLP_FLT_CAR_LSB 0
`define CLP_FLT_CAR_MSB 2
`define CLP_FLT_COL_LSB 4
`define CLP_FLT_COL_MSB 6
// Reset values
`define CLP_MODE_RESET 32'h00008000
`define CLP_TIMING_RESET 32'h00600600
`define CLP_SLOT_RESET 32'h00400200
`define CLP_FILTER_RESET 32'h00000000
// Timing and length constants
`define CLP_IFS_MIN 8'h20
`define CLP_SLOT_ZERO 12'h800
`define CLP_BO_CAP 5'h0A
`define CLP_RUNT_BYTES 16'h0006
`define CLP_EXT_LIMIT 5'h12
`define CLP_DIV_LAST 2'h3
`endif

// ===== hdl/clp_link_param.v
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "clp_regs.vh"

// Three-stage pin synchroniser; level moves when stages two and three agree
module clp_pin_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] level
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;

    // Shift chain and agreement check
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= {WIDTH{1'b0}};
            s2_r <= {WIDTH{1'b0}};
            s3_r <= {WIDTH{1'b0}};
            level <= {WIDTH{1'b0}};
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level <= (s2_r & s3_r) | (level & (s2_r ^ s3_r));
        end
    end
endmodule // clp_pin_sync

//Contract
//- Buffer placement: no source address insertion
//- Internal loopback detaches, loops, divides clock
//- External loopback: full rate, 18-byte frame
//- Linear priority wait, then carrier check
//- Backoff random below 2^min(n+prio,10)
//- Backoff starts after jam or deferral
//- Interframe spacing clamped to at least 32
//- Readback returns interframe spacing as written
//- Slot time in clocks, zero means 2048
//- Promiscuous accepts every destination
//- Broadcast disable rejects broadcasts unless promiscuous
//- Encoding bit: NRZ or Manchester
//- Option allows transmit without returned carrier
//- CRC appended unless suppression bit set
//- CRC select: 32-bit or 16-bit polynomial
//- Framing select: end-of-carrier or bit-stuffed
//- Padding flags extend short bit-stuffed frames
//- Carrier filtered on rise, dropped at once
//- External collision filtered; source bit selects
//- Reject below minimum; silently drop under 6
//- Separate addresses: reject below 2*len+2
//- Preamble field selects 2,4,8,16 bytes
//- Descriptor placement: device inserts source address
module clp_link_param (
    input wire I_CLK,
    input wire I_RESET,
    input wire [3:0] I_ADDR,
    input wire [31:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [31:0] O_RDATA,
    input wire I_TRANSMIT_CLOCK,
    input wire I_RECEIVE_CLOCK,
    input wire I_RXD_PIN,
    input wire I_CARRIER_SENSE,
    input wire I_COLLISION_DETECT,
    input wire I_TXD,
    input wire I_INT_CARRIER,
    input wire I_INT_COLL,
    input wire I_TX_REQ,
    input wire I_TX_DATA_DONE,
    input wire I_TX_DONE,
    input wire I_JAM_DONE,
    input wire I_RX_END,
    input wire [15:0] I_RX_LEN,
    input wire I_RX_BCAST,
    input wire I_RX_MATCH,
    output reg O_TXD_PIN,
    output reg O_LINE_EN,
    output reg O_RXD,
    output reg O_RX_TICK,
    output reg O_TX_TICK,
    output reg O_CARRIER,
    output reg O_COLLISION,
    output reg O_TX_GO,
    output reg O_CARRIER_LOST,
    output reg O_SEND_FLAGS,
    output reg O_RX_ACCEPT,
    output reg O_RX_REJECT,
    output reg O_INSERT_SRC,
    output reg O_APPEND_CRC,
    output reg O_CRC16,
    output reg O_BITSTUFF,
    output reg O_MANCHESTER,
    output reg O_FULL_DUPLEX,
    output reg [4:0] O_TX_BYTE_LIMIT,
    output reg [4:0] O_PREAMBLE_BYTES,
    output reg [2:0] O_ADDR_BYTES
);
    // Deferral states, one-hot
    localparam [5:0] ST_DEFER = 6'h01;
    localparam [5:0] ST_IFS = 6'h02;
    localparam [5:0] ST_PRIO = 6'h04;
    localparam [5:0] ST_READY = 6'h08;
    localparam [5:0] ST_TX = 6'h10;
    localparam [5:0] ST_SPARE = 6'h20;

    reg [31:0] mode_r, timing_r, slot_r, filter_r;
    wire [4:0] pin_lvl;
    reg tclk_last_r, rclk_last_r;
    reg [1:0] div_r;
    wire tclk_rise, rclk_rise, tick, int_loop;
    wire [7:0] ifs_raw, ifs_eff;
    wire [11:0] slot_eff;
    wire [2:0] lin_prio, exp_prio, alen_eff;
    reg [2:0] car_cnt_r, col_cnt_r;
    reg carrier_ok_r, coll_ext_ok_r;
    wire carrier_raw, coll_ok;
    reg [5:0] state_r, state_nxt;
    reg [7:0] ifs_cnt_r;
    reg [13:0] wait_cnt_r;
    reg [15:0] lfsr_r;
    reg [3:0] coll_num_r;
    reg bo_pend_r, bo_run_r;
    reg [9:0] bo_slots_r;
    reg [11:0] bo_tcnt_r, act_cnt_r;
    wire [4:0] bo_exp_sum;
    wire [3:0] bo_exp;
    wire [9:0] bo_mask, bo_rand;
    wire bo_start;
    reg carrier_seen_r;
    wire [15:0] fcs_bytes, rx_total, sep_min;
    wire rx_runt, rx_short, rx_addr_ok;

    // Pin inputs: transmit clock, receive clock, data, carrier, collision
    clp_pin_sync #(
        .WIDTH(5)
    ) u_sync (
        .clk(I_CLK),
        .rst(I_RESET),
        .din({I_COLLISION_DETECT, I_CARRIER_SENSE, I_RXD_PIN, I_RECEIVE_CLOCK,
              I_TRANSMIT_CLOCK}),
        .level(pin_lvl)
    );

    // Configuration field decode
    assign int_loop = mode_r[`CLP_MODE_INT_LOOP];
    assign ifs_raw = timing_r[`CLP_TIM_IFS_MSB:`CLP_TIM_IFS_LSB];
    assign ifs_eff = (ifs_raw < `CLP_IFS_MIN) ? `CLP_IFS_MIN : ifs_raw;
    assign slot_eff = (slot_r[`CLP_SLOT_MSB:`CLP_SLOT_LSB] == 11'h000) ?
                      `CLP_SLOT_ZERO : {1'b0, slot_r[`CLP_SLOT_MSB:`CLP_SLOT_LSB]};
    assign lin_prio = timing_r[`CLP_TIM_LIN_MSB:`CLP_TIM_LIN_LSB];
    assign exp_prio = timing_r[`CLP_TIM_EXP_MSB:`CLP_TIM_EXP_LSB];
    assign alen_eff = (timing_r[`CLP_TIM_ALEN_MSB:`CLP_TIM_ALEN_LSB] == 3'h7) ?
                      3'h0 : timing_r[`CLP_TIM_ALEN_MSB:`CLP_TIM_ALEN_LSB];

    // Clock edges and the divided bit tick
    assign tclk_rise = pin_lvl[0] & ~tclk_last_r;
    assign rclk_rise = pin_lvl[1] & ~rclk_last_r;
    assign tick = tclk_rise & (~int_loop | (div_r == `CLP_DIV_LAST));

    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            tclk_last_r <= 1'b0;
            rclk_last_r <= 1'b0;
            div_r <= 2'h0;
        end else begin
            tclk_last_r <= pin_lvl[0];
            rclk_last_r <= pin_lvl[1];
            if (tclk_rise) begin
                div_r <= div_r + 2'h1;
            end
        end
    end

    // Register writes
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            mode_r <= `CLP_MODE_RESET;
            timing_r <= `CLP_TIMING_RESET;
            slot_r <= `CLP_SLOT_RESET;
            filter_r <= `CLP_FILTER_RESET;
        end else if (I_WR) begin
            case (I_ADDR)
                `CLP_ADDR_MODE: mode_r <= {16'h0000, I_WDATA[15:0]};
                `CLP_ADDR_TIMING: timing_r <= I_WDATA & 32'h00FF0777;
                `CLP_ADDR_SLOT: slot_r <= I_WDATA & 32'h00FF07FF;
                `CLP_ADDR_FILTER: filter_r <= I_WDATA & 32'h00000077;
                default: ;
            endcase
        end
    end

    // Register reads, data valid one cycle after the strobe
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_RDATA <= 32'h00000000;
        end else if (I_RD) begin
            case (I_ADDR)
                `CLP_ADDR_MODE: O_RDATA <= mode_r;
                `CLP_ADDR_TIMING: O_RDATA <= timing_r;
                `CLP_ADDR_SLOT: O_RDATA <= slot_r;
                `CLP_ADDR_FILTER: O_RDATA <= filter_r;
                `CLP_ADDR_STATUS: O_RDATA <= {15'h0000, bo_run_r, coll_num_r, 2'h0,
                                              coll_ok, carrier_ok_r, 2'h0, state_r};
                default: O_RDATA <= 32'h00000000;
            endcase
        end else begin
            O_RDATA <= 32'h00000000;
        end
    end

    // Carrier and collision source select and width filters
    assign carrier_raw = mode_r[`CLP_MODE_INT_CARRIER] ? I_INT_CARRIER : pin_lvl[3];
    assign coll_ok = mode_r[`CLP_MODE_INT_COLL] ? I_INT_COLL : coll_ext_ok_r;

    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            car_cnt_r <= 3'h0;
            col_cnt_r <= 3'h0;
            carrier_ok_r <= 1'b0;
            coll_ext_ok_r <= 1'b0;
        end else begin
            if (!carrier_raw) begin
                car_cnt_r <= 3'h0;
                carrier_ok_r <= 1'b0;
            end else if (car_cnt_r >= filter_r[`CLP_FLT_CAR_MSB:`CLP_FLT_CAR_LSB]) begin
                carrier_ok_r <= 1'b1;
            end else if (tick) begin
                car_cnt_r <= car_cnt_r + 3'h1;
            end
            if (!pin_lvl[4]) begin
                col_cnt_r <= 3'h0;
                coll_ext_ok_r <= 1'b0;
            end else if (col_cnt_r >= filter_r[`CLP_FLT_COL_MSB:`CLP_FLT_COL_LSB]) begin
                coll_ext_ok_r <= 1'b1;
            end else if (tick) begin
                col_cnt_r <= col_cnt_r + 3'h1;
            end
        end
    end

    // Backoff draw: random value masked to the capped exponent
    assign bo_exp_sum = {1'b0, coll_num_r} + {2'h0, exp_prio};
    assign bo_exp = (bo_exp_sum > `CLP_BO_CAP) ? 4'hA : bo_exp_sum[3:0];
    assign bo_mask = ~(10'h3FF << bo_exp);
    assign bo_rand = lfsr_r[9:0] & bo_mask;
    assign bo_start = (I_JAM_DONE & ~mode_r[`CLP_MODE_BACKOFF_MET]) |
                      (bo_pend_r & (state_r == ST_IFS) & tick &
                       (ifs_cnt_r >= ifs_eff - 8'h01));

    // Collision counter, random source and backoff timer
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            lfsr_r <= 16'hACE1;
            coll_num_r <= 4'h0;
            bo_pend_r <= 1'b0;
            bo_run_r <= 1'b0;
            bo_slots_r <= 10'h000;
            bo_tcnt_r <= 12'h000;
        end else begin
            lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
            if (I_JAM_DONE) begin
                coll_num_r <= (coll_num_r == 4'hF) ? coll_num_r : coll_num_r + 4'h1;
            end else if (I_TX_DONE) begin
                coll_num_r <= 4'h0;
            end
            if (I_JAM_DONE && mode_r[`CLP_MODE_BACKOFF_MET]) begin
                bo_pend_r <= 1'b1;
            end else if (bo_start) begin
                bo_pend_r <= 1'b0;
            end
            if (bo_start) begin
                bo_slots_r <= bo_rand;
                bo_tcnt_r <= 12'h000;
                bo_run_r <= (bo_rand != 10'h000);
            end else if (bo_run_r && tick) begin
                if (bo_tcnt_r == slot_eff - 12'h001) begin
                    bo_tcnt_r <= 12'h000;
                    bo_slots_r <= bo_slots_r - 10'h001;
                    if (bo_slots_r == 10'h001) begin
                        bo_run_r <= 1'b0;
                    end
                end else begin
                    bo_tcnt_r <= bo_tcnt_r + 12'h001;
                end
            end
        end
    end

    // Deferral sequence: carrier gone, spacing, priority wait, send
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_DEFER: begin
                if (!carrier_ok_r) begin
                    state_nxt = ST_IFS;
                end
            end
            ST_IFS: begin
                if (carrier_ok_r) begin
                    state_nxt = ST_DEFER;
                end else if (tick && ifs_cnt_r >= ifs_eff - 8'h01) begin
                    state_nxt = (lin_prio == 3'h0) ? ST_READY : ST_PRIO;
                end
            end
            ST_PRIO: begin
                if (tick && wait_cnt_r == 14'h0001) begin
                    state_nxt = carrier_ok_r ? ST_DEFER : ST_READY;
                end
            end
            ST_READY: begin
                if (I_TX_REQ && !bo_run_r && !bo_pend_r) begin
                    state_nxt = ST_TX;
                end else if (carrier_ok_r) begin
                    state_nxt = ST_DEFER;
                end
            end
            ST_TX: begin
                if (I_TX_DONE || I_JAM_DONE) begin
                    state_nxt = ST_DEFER;
                end
            end
            default: state_nxt = ST_DEFER;
        endcase
    end

    // State register and its counters
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_r <= ST_DEFER;
            ifs_cnt_r <= 8'h00;
            wait_cnt_r <= 14'h0000;
            act_cnt_r <= 12'h000;
            carrier_seen_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r != ST_IFS) begin
                ifs_cnt_r <= 8'h00;
            end else if (tick) begin
                ifs_cnt_r <= ifs_cnt_r + 8'h01;
            end
            if (state_r != ST_PRIO) begin
                wait_cnt_r <= {11'h000, lin_prio} * {2'h0, slot_eff};
            end else if (tick) begin
                wait_cnt_r <= wait_cnt_r - 14'h0001;
            end
            if (state_r != ST_TX) begin
                act_cnt_r <= 12'h000;
                carrier_seen_r <= 1'b0;
            end else begin
                if (tick && act_cnt_r != 12'hFFF) begin
                    act_cnt_r <= act_cnt_r + 12'h001;
                end
                if (carrier_ok_r) begin
                    carrier_seen_r <= 1'b1;
                end
            end
        end
    end

    // Receive length and address filter
    assign fcs_bytes = mode_r[`CLP_MODE_CRC16] ? 16'h0002 : 16'h0004;
    assign rx_total = I_RX_LEN + fcs_bytes;
    assign sep_min = {12'h000, alen_eff, 1'b0} + 16'h0002;
    assign rx_runt = rx_total < `CLP_RUNT_BYTES;
    assign rx_short = (rx_total < {8'h00, slot_r[`CLP_MINF_MSB:`CLP_MINF_LSB]}) |
                      (~mode_r[`CLP_MODE_ADDR_PLACE] & (I_RX_LEN < sep_min));
    assign rx_addr_ok = mode_r[`CLP_MODE_PROMISC] |
                        (I_RX_BCAST ? ~mode_r[`CLP_MODE_BCAST_DIS] : I_RX_MATCH);

    // Frame events and receive routing
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_TX_GO <= 1'b0;
            O_CARRIER_LOST <= 1'b0;
            O_SEND_FLAGS <= 1'b0;
            O_RX_ACCEPT <= 1'b0;
            O_RX_REJECT <= 1'b0;
            O_TXD_PIN <= 1'b0;
            O_RXD <= 1'b0;
            O_RX_TICK <= 1'b0;
            O_TX_TICK <= 1'b0;
            O_CARRIER <= 1'b0;
            O_COLLISION <= 1'b0;
        end else begin
            O_TX_GO <= (state_r == ST_READY) & (state_nxt == ST_TX);
            O_CARRIER_LOST <= I_TX_DONE & (state_r == ST_TX) & ~carrier_seen_r &
                              ~mode_r[`CLP_MODE_TX_NO_CARRIER];
            O_SEND_FLAGS <= mode_r[`CLP_MODE_PAD] & mode_r[`CLP_MODE_BITSTUFF] &
                            (state_r == ST_TX) & I_TX_DATA_DONE &
                            (act_cnt_r < slot_eff);
            O_RX_ACCEPT <= I_RX_END & ~rx_runt & ~rx_short & rx_addr_ok;
            O_RX_REJECT <= I_RX_END & ~rx_runt & (rx_short | ~rx_addr_ok);
            O_TXD_PIN <= I_TXD & ~int_loop;
            O_RXD <= int_loop ? I_TXD : pin_lvl[2];
            O_RX_TICK <= int_loop ? tick : rclk_rise;
            O_TX_TICK <= tick;
            O_CARRIER <= carrier_ok_r;
            O_COLLISION <= coll_ok;
        end
    end

    // Registered configuration outputs
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_LINE_EN <= 1'b1;
            O_INSERT_SRC <= 1'b1;
            O_APPEND_CRC <= 1'b1;
            O_CRC16 <= 1'b0;
            O_BITSTUFF <= 1'b0;
            O_MANCHESTER <= 1'b0;
            O_FULL_DUPLEX <= 1'b0;
            O_TX_BYTE_LIMIT <= 5'h00;
            O_PREAMBLE_BYTES <= 5'h08;
            O_ADDR_BYTES <= 3'h6;
        end else begin
            O_LINE_EN <= ~int_loop;
            O_INSERT_SRC <= ~mode_r[`CLP_MODE_ADDR_PLACE];
            O_APPEND_CRC <= ~mode_r[`CLP_MODE_NO_CRC];
            O_CRC16 <= mode_r[`CLP_MODE_CRC16];
            O_BITSTUFF <= mode_r[`CLP_MODE_BITSTUFF];
            O_MANCHESTER <= mode_r[`CLP_MODE_MANCH];
            O_FULL_DUPLEX <= int_loop | mode_r[`CLP_MODE_EXT_LOOP];
            O_TX_BYTE_LIMIT <= (mode_r[`CLP_MODE_EXT_LOOP] & ~int_loop) ?
                               `CLP_EXT_LIMIT : 5'h00;
            O_PREAMBLE_BYTES <= 5'h02 << mode_r[`CLP_MODE_PREAM_MSB:`CLP_MODE_PREAM_LSB];
            O_ADDR_BYTES <= alen_eff;
        end
    end
endmodule // clp_link_param

// ===== verification/clp_link_monitor.sv
`timescale 1ns/1ps
// Port-level checks of the link parameter block
module clp_link_monitor (
    input wire I_CLK,
    input wire I_RESET,
    input wire [3:0] I_ADDR,
    input wire [31:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    input wire [31:0] O_RDATA,
    input wire I_TXD,
    input wire I_INT_CARRIER,
    input wire I_RX_END,
    input wire [15:0] I_RX_LEN,
    input wire O_TXD_PIN,
    input wire O_LINE_EN,
    input wire O_CARRIER,
    input wire O_TX_GO,
    input wire O_RX_ACCEPT,
    input wire O_RX_REJECT,
    input wire O_INSERT_SRC,
    input wire O_APPEND_CRC,
    input wire O_CRC16,
    input wire O_BITSTUFF,
    input wire O_MANCHESTER,
    input wire [4:0] O_TX_BYTE_LIMIT,
    input wire [4:0] O_PREAMBLE_BYTES
);
    reg [15:0] mode_r;
    reg [1:0] age_r;
    wire settled = age_r == 2'h2;
    // Shadow of the mode word and cycles since it was written
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            mode_r <= 16'h8000;
            age_r <= 2'h2;
        end else if (I_WR && I_ADDR == 4'h0) begin
            mode_r <= I_WDATA[15:0];
            age_r <= 2'h0;
        end else if (!settled) begin
            age_r <= age_r + 2'h1;
        end
    end
    default clocking @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);
    // Bus, configuration, receive and carrier outputs
    rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
        else $error("read data outside its cycle");
    ifs_back_a: assert property (I_WR && I_ADDR == 4'h1 ##1 I_RD && I_ADDR == 4'h1
        |=> O_RDATA[23:16] == $past(I_WDATA[23:16], 2)) else $error("spacing readback differs");
    detach_a: assert property (!O_LINE_EN |-> !O_TXD_PIN)
        else $error("line driven while detached");
    loop_cfg_a: assert property (settled |-> O_LINE_EN == !mode_r[1]
        && O_TX_BYTE_LIMIT == ((mode_r[2] && !mode_r[1]) ? 5'h12 : 5'h0))
        else $error("loopback outputs wrong");
    crc_cfg_a: assert property (settled |-> O_APPEND_CRC == !mode_r[7]
        && O_CRC16 == mode_r[8]) else $error("crc outputs wrong");
    frame_cfg_a: assert property (settled |-> O_BITSTUFF == mode_r[9]
        && O_MANCHESTER == mode_r[5] && O_INSERT_SRC == !mode_r[0])
        else $error("framing outputs wrong");
    preamble_len_a: assert property (settled |-> O_PREAMBLE_BYTES == 5'h2 << mode_r[15:14])
        else $error("preamble length wrong");
    runt_drop_a: assert property (I_RX_END && I_RX_LEN < (O_CRC16 ? 16'h4 : 16'h2)
        |=> !O_RX_ACCEPT && !O_RX_REJECT) else $error("runt frame reported");
    rx_verdict_a: assert property (O_RX_ACCEPT || O_RX_REJECT |-> $past(I_RX_END)
        && !(O_RX_ACCEPT && O_RX_REJECT)) else $error("receive verdict without cause");
    carrier_drop_a: assert property (settled && mode_r[11] && !I_INT_CARRIER |=> ##1 !O_CARRIER)
        else $error("carrier loss not immediate");
    // Main scenarios reached
    cover property (O_TX_GO);
    cover property (O_RX_ACCEPT);
    cover property (O_RX_REJECT);
endmodule // clp_link_monitor

bind clp_link_param clp_link_monitor u_mon (
    .I_CLK, .I_RESET, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_TXD, .I_INT_CARRIER,
    .I_RX_END, .I_RX_LEN, .O_TXD_PIN, .O_LINE_EN, .O_CARRIER, .O_TX_GO, .O_RX_ACCEPT,
    .O_RX_REJECT, .O_INSERT_SRC, .O_APPEND_CRC, .O_CRC16, .O_BITSTUFF, .O_MANCHESTER,
    .O_TX_BYTE_LIMIT, .O_PREAMBLE_BYTES
);

// ===== verification/clp_xcvr_model.sv
`timescale 1ns/1ps
// Serial transceiver: bit clocks, line echo, carrier and collision pins
module clp_xcvr_model (
    input wire i_txd,
    input wire i_line_en,
    input wire i_crs_cmd,
    input wire i_cdt_cmd,
    output reg o_tx_clock,
    output wire o_rx_clock,
    output reg o_rxd = 1'b0,
    output wire o_carrier,
    output wire o_collision
);
    // Free bit clock, 16 ns, unrelated in phase to the system clock
    initial begin
        o_tx_clock = 1'b0;
        #3;
        forever #8 o_tx_clock = ~o_tx_clock;
    end
    // Receive clock is the transmit clock gated by the line enable, so present only while attached
    assign o_rx_clock = i_line_en & o_tx_clock;
    // Echo while attached, a changing pattern once released
    always @(posedge o_tx_clock) begin
        o_rxd <= i_line_en ? i_txd : ~o_rxd;
    end
    assign o_carrier = i_crs_cmd;
    assign o_collision = i_cdt_cmd;
endmodule // clp_xcvr_model

// ===== verification/clp_link_param_test.sv
`timescale 1ns/1ps
module clp_link_param_test;
    reg I_CLK = 1'b0;
    reg I_RESET = 1'b1;
    reg [3:0] I_ADDR = 4'h0;
    reg [31:0] I_WDATA = 32'h0;
    reg [15:0] I_RX_LEN = 16'h0;
    reg I_WR = 1'b0, I_RD = 1'b0, I_TXD = 1'b0, I_INT_CARRIER = 1'b0, I_INT_COLL = 1'b0;
    reg I_TX_REQ = 1'b0, I_TX_DATA_DONE = 1'b0, I_TX_DONE = 1'b0, I_JAM_DONE = 1'b0;
    reg I_RX_END = 1'b0, I_RX_BCAST = 1'b0, I_RX_MATCH = 1'b0, crs_cmd = 1'b0;
    wire [31:0] O_RDATA;
    wire [4:0] O_TX_BYTE_LIMIT, O_PREAMBLE_BYTES;
    wire [2:0] O_ADDR_BYTES;
    wire I_TRANSMIT_CLOCK, I_RECEIVE_CLOCK, I_RXD_PIN, I_CARRIER_SENSE, I_COLLISION_DETECT;
    wire O_TXD_PIN, O_LINE_EN, O_RXD, O_RX_TICK, O_TX_TICK, O_CARRIER, O_COLLISION, O_TX_GO;
    wire O_CARRIER_LOST, O_SEND_FLAGS, O_RX_ACCEPT, O_RX_REJECT, O_INSERT_SRC, O_APPEND_CRC;
    wire O_CRC16, O_BITSTUFF, O_MANCHESTER, O_FULL_DUPLEX;
    int n_errors = 0;
    int compares = 0;

    clp_link_param u_dut (
        .I_CLK, .I_RESET, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_TRANSMIT_CLOCK,
        .I_RECEIVE_CLOCK, .I_RXD_PIN, .I_CARRIER_SENSE, .I_COLLISION_DETECT, .I_TXD,
        .I_INT_CARRIER, .I_INT_COLL, .I_TX_REQ, .I_TX_DATA_DONE, .I_TX_DONE, .I_JAM_DONE,
        .I_RX_END, .I_RX_LEN, .I_RX_BCAST, .I_RX_MATCH, .O_TXD_PIN, .O_LINE_EN, .O_RXD,
        .O_RX_TICK, .O_TX_TICK, .O_CARRIER, .O_COLLISION, .O_TX_GO, .O_CARRIER_LOST,
        .O_SEND_FLAGS, .O_RX_ACCEPT, .O_RX_REJECT, .O_INSERT_SRC, .O_APPEND_CRC, .O_CRC16,
        .O_BITSTUFF, .O_MANCHESTER, .O_FULL_DUPLEX, .O_TX_BYTE_LIMIT, .O_PREAMBLE_BYTES,
        .O_ADDR_BYTES
    );
    clp_xcvr_model u_xcvr (
        .i_txd(O_TXD_PIN), .i_line_en(O_LINE_EN), .i_crs_cmd(crs_cmd), .i_cdt_cmd(1'b0),
        .o_tx_clock(I_TRANSMIT_CLOCK), .o_rx_clock(I_RECEIVE_CLOCK), .o_rxd(I_RXD_PIN),
        .o_carrier(I_CARRIER_SENSE), .o_collision(I_COLLISION_DETECT)
    );

    // System clock, 4 ns
    initial begin
        forever #2 I_CLK = ~I_CLK;
    end
    // Changing serial data from the transmit side
    always @(posedge I_CLK) begin
        I_TXD <= ~I_TXD;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Bus cycles, entered just after a rising edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        @(negedge I_CLK);
        check(O_RDATA, exp);
        @(posedge I_CLK);
    endtask

    // One received frame end; exp 0 silent, 1 accepted, 2 rejected
    task automatic rx_case(input logic [15:0] m, input logic [7:0] minf, input logic [15:0] len,
                           input logic bc, mt, input logic [1:0] exp);
        wr(4'h0, {16'h0, m});
        @(posedge I_CLK);
        wr(4'h2, {8'h0, minf, 16'h0200});
        @(posedge I_CLK);
        I_RX_END <= 1'b1;
        I_RX_LEN <= len;
        I_RX_BCAST <= bc;
        I_RX_MATCH <= mt;
        @(posedge I_CLK);
        I_RX_END <= 1'b0;
        @(negedge I_CLK);
        check({O_RX_REJECT, O_RX_ACCEPT}, exp);
        @(posedge I_CLK);
    endtask

    // Time from carrier loss to start, then the carrier-lost report
    task automatic go_case(input logic [15:0] m, input logic [31:0] tim, slot,
                           input int ticks, input logic lost);
        int n, lim;
        logic seen;
        lim = ticks * (m[1] ? 16 : 4);
        I_INT_CARRIER <= 1'b1;
        wr(4'h0, {16'h0, m | 16'h8800});
        @(posedge I_CLK);
        wr(4'h1, tim);
        rd_chk(4'h1, tim);
        wr(4'h2, slot);
        repeat (4) @(posedge I_CLK);
        I_TX_REQ <= 1'b1;
        @(posedge I_CLK);
        I_INT_CARRIER <= 1'b0;
        n = 0;
        while (O_TX_GO !== 1'b1 && n < lim + 100) begin
            @(negedge I_CLK);
            n++;
        end
        check((n > lim - 24 && n < lim + 24) ? lim : n, lim);
        @(posedge I_CLK);
        I_TX_DONE <= 1'b1;
        @(posedge I_CLK);
        I_TX_DONE <= 1'b0;
        I_TX_REQ <= 1'b0;
        seen = 1'b0;
        repeat (3) begin
            @(negedge I_CLK);
            seen |= O_CARRIER_LOST;
        end
        check(seen, lost);
        @(posedge I_CLK);
        $display("transmit case done");
    endtask

    // Hang guard
    initial begin
        #100000;
        n_errors++;
        test_done();
    end

    // Reset, registers, receive filter, then deferral timing
    initial begin
        repeat (20) @(posedge I_CLK);
        I_RESET <= 1'b0;
        @(posedge I_CLK);
        rd_chk(4'h0, 32'h00008000);
        rd_chk(4'h1, 32'h00600600);
        rd_chk(4'h2, 32'h00400200);
        wr(4'h5, 32'h00000FFF);
        rd_chk(4'h3, 32'h00000000);
        rd_chk(4'h5, 32'h00000000);
        rd_chk(4'h4, 32'h00000002);
        $display("register test done");
        rx_case(16'h0000, 8'h40, 16'd1, 1'b0, 1'b1, 2'd0);
        rx_case(16'h4000, 8'h40, 16'd60, 1'b0, 1'b1, 2'd1);
        rx_case(16'h8000, 8'h40, 16'd59, 1'b0, 1'b1, 2'd2);
        rx_case(16'hC000, 8'h40, 16'd60, 1'b0, 1'b0, 2'd2);
        rx_case(16'h8000, 8'h40, 16'd60, 1'b1, 1'b0, 2'd1);
        rx_case(16'h8010, 8'h40, 16'd60, 1'b1, 1'b1, 2'd2);
        rx_case(16'h8018, 8'h40, 16'd60, 1'b1, 1'b0, 2'd1);
        rx_case(16'h8008, 8'h40, 16'd60, 1'b0, 1'b0, 2'd1);
        rx_case(16'h8000, 8'h06, 16'd13, 1'b0, 1'b1, 2'd2);
        rx_case(16'h8000, 8'h06, 16'd14, 1'b0, 1'b1, 2'd1);
        rx_case(16'h8225, 8'h06, 16'd13, 1'b0, 1'b1, 2'd1);
        rx_case(16'h8101, 8'h06, 16'd3, 1'b0, 1'b1, 2'd0);
        rx_case(16'h8181, 8'h06, 16'd4, 1'b0, 1'b1, 2'd1);
        $display("receive test done");
        go_case(16'h0000, 32'h00080000, 32'h00400200, 32, 1'b1);
        go_case(16'h0040, 32'h00280000, 32'h00400200, 40, 1'b0);
        go_case(16'h0000, 32'h00200001, 32'h00400032, 82, 1'b1);
        go_case(16'h0000, 32'h00200001, 32'h00400000, 2080, 1'b1);
        go_case(16'h0006, 32'h00200000, 32'h00400200, 32, 1'b1);
        test_done();
    end
endmodule // clp_link_param_test
